/* File: atpc_consts.vh */
// register map, field layout, reset values and timing constants of the converter timing block
`ifndef ATPC_CONSTS_VH
`define ATPC_CONSTS_VH

// register word indices; the bus byte address is the index times four
`define ATPC_IDX_SETTLE 12'hF74
`define ATPC_IDX_SAMPLE 12'hF75
`define ATPC_IDX_DIVIDER 12'hF76
`define ATPC_IDX_START 12'hF77
`define ATPC_ADDR_W 14

// field layout
`define ATPC_SETTLE_W 4
`define ATPC_SAMPLE_W 6
`define ATPC_DIV_W 3
`define ATPC_HALF_BIT 0
`define ATPC_QUARTER_BIT 1
`define ATPC_EIGHTH_BIT 2
`define ATPC_START_BIT 7

// reset values
`define ATPC_SETTLE_RST 4'hF
`define ATPC_SAMPLE_RST 6'h3F
`define ATPC_DIV_RST 3'h0

// timing figures in nanoseconds and the system clock period
`define ATPC_CLK_PERIOD_NS 5
`define ATPC_SETTLE_MIN_NS 500
`define ATPC_SAMPLE_MIN_NS 1000
`define ATPC_SETTLE_MIN_CYC ((`ATPC_SETTLE_MIN_NS + `ATPC_CLK_PERIOD_NS - 1) / `ATPC_CLK_PERIOD_NS)
`define ATPC_SAMPLE_MIN_CYC ((`ATPC_SAMPLE_MIN_NS + `ATPC_CLK_PERIOD_NS - 1) / `ATPC_CLK_PERIOD_NS)

// conversion length in converter clock ticks after the sample phase
`define ATPC_CONV_TICKS 10

`endif

/* File: atpc_ctrl.v */
// converter timing and prescale control with an Avalon-MM register slave
//
// How it works
// - settling count in bits 3:0, resets all ones
// - sample/hold count in bits 5:0
// - bit 0 set divides converter clock by two when bits 2:1 are clear
// - bit 1 set divides converter clock by four when bit 2 is clear
// - bit 2 set divides converter clock by eight
// - start bit one starts; reads busy status
`timescale 1ns/10ps
`include "atpc_consts.vh"
module atpc_ctrl (
    // clock and reset
    input wire sys_clk_i,
    input wire sys_rst_i,
    // avalon-mm slave
    input wire [`ATPC_ADDR_W-1:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output reg [31:0] avs_readdata_o,
    output wire avs_waitrequest_o,
    // converter core side
    output wire adc_tick_o,
    output wire [3:0] adc_divisor_o,
    output wire adc_busy_o,
    output wire adc_settle_o,
    output wire adc_sample_o,
    output wire adc_done_o
);
    // settings registers
    reg [`ATPC_SETTLE_W-1:0] settle_count;
    reg [`ATPC_SAMPLE_W-1:0] sample_hold_count;
    reg [`ATPC_DIV_W-1:0] div_sel;
    reg start_pulse;
    reg ack;
    reg [31:0] next_readdata;
    wire req;
    wire wr_lo;
    wire tick;
    wire busy;

    // word index from byte address
    function [11:0] word_idx;
        input [`ATPC_ADDR_W-1:0] a;
        begin
            word_idx = a[`ATPC_ADDR_W-1:2];
        end
    endfunction

    // one wait state per access: request taken at the edge where ack is high
    assign req = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = req & ~ack;
    assign wr_lo = avs_write_i & ack & avs_byteenable_i[0];

    // reserved bits are dropped on write and read back as zero
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            settle_count <= `ATPC_SETTLE_RST;
            sample_hold_count <= `ATPC_SAMPLE_RST;
            div_sel <= `ATPC_DIV_RST;
            start_pulse <= 1'b0;
            ack <= 1'b0;
        end else begin
            ack <= req & ~ack;
            start_pulse <= 1'b0;
            if (wr_lo) begin
                case (word_idx(avs_address_i))
                    `ATPC_IDX_SETTLE: settle_count <= avs_writedata_i[3:0];
                    `ATPC_IDX_SAMPLE: sample_hold_count <= avs_writedata_i[5:0];
                    `ATPC_IDX_DIVIDER: div_sel <= avs_writedata_i[2:0];
                    `ATPC_IDX_START: start_pulse <= avs_writedata_i[`ATPC_START_BIT];
                    default: start_pulse <= 1'b0;
                endcase
            end
        end
    end

    // read mux; unmapped addresses read zero
    always @* begin
        next_readdata = 32'h0000_0000;
        case (word_idx(avs_address_i))
            `ATPC_IDX_SETTLE: next_readdata = {28'h0, settle_count};
            `ATPC_IDX_SAMPLE: next_readdata = {26'h0, sample_hold_count};
            `ATPC_IDX_DIVIDER: next_readdata = {29'h0, div_sel};
            `ATPC_IDX_START: next_readdata = {24'h0, busy, 7'h00};
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    // read data registered so it stands at the completing edge
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i & ~ack) begin
            avs_readdata_o <= next_readdata;
        end
    end

    atpc_prescaler u_prescaler (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .div_sel_i(div_sel),
        .tick_o(tick),
        .divisor_o(adc_divisor_o)
    );

    // a start written while busy is ignored by the idle-only sequencer
    atpc_sequencer u_sequencer (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .tick_i(tick),
        .start_i(start_pulse),
        .settle_count_i(settle_count),
        .sample_hold_count_i(sample_hold_count),
        .busy_o(busy),
        .settle_o(adc_settle_o),
        .sample_o(adc_sample_o),
        .done_o(adc_done_o)
    );

    assign adc_tick_o = tick;
    assign adc_busy_o = busy;
endmodule

/* File: atpc_ctrl_assertions.sv */
// port checks for the converter timing block
`timescale 1ns/10ps
module atpc_ctrl_chk (
    // clock, reset, bus
    input wire sys_clk_i,
    input wire sys_rst_i,
    input wire [13:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    input wire [31:0] avs_readdata_o,
    input wire avs_waitrequest_o,
    // converter side
    input wire adc_tick_o,
    input wire [3:0] adc_divisor_o,
    input wire adc_busy_o,
    input wire adc_settle_o,
    input wire adc_sample_o,
    input wire adc_done_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    AST_WAIT: assert property ($rose(avs_read_i || avs_write_i) |->
        avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("wait state count");
    AST_RST: assert property ($fell(sys_rst_i) |-> avs_readdata_o == 0 &&
        adc_divisor_o == 4'h1 && !adc_busy_o) else $error("reset state");
    AST_HALF_RATE_SELECT: assert property (adc_tick_o && adc_divisor_o == 4'h2 |=>
        !adc_tick_o || adc_divisor_o != 4'h2) else $error("half rate tick");
    AST_QUARTER_RATE_SELECT: assert property (adc_tick_o && adc_divisor_o == 4'h4 |=>
        (!adc_tick_o || adc_divisor_o != 4'h4)[*3]) else $error("quarter rate tick");
    AST_EIGHTH_RATE_SELECT: assert property (adc_tick_o && adc_divisor_o == 4'h8 |=>
        (!adc_tick_o || adc_divisor_o != 4'h8)[*7]) else $error("eighth rate tick");
    AST_ONE: assert property (adc_divisor_o inside {4'h1, 4'h2, 4'h4, 4'h8})
        else $error("undefined rate");
    // a start write on the completing edge opens the settle phase shortly after
    AST_START: assert property (avs_write_i && !avs_waitrequest_o &&
        avs_address_i == 14'h3DDC && avs_writedata_i[7] && avs_byteenable_i[0] &&
        !adc_busy_o |-> ##[1:3] adc_busy_o && adc_settle_o) else $error("no start");
    AST_DONE: assert property ($fell(adc_busy_o) |-> adc_done_o)
        else $error("no done pulse");
    AST_PHASE: assert property (adc_sample_o |-> adc_busy_o && !adc_settle_o)
        else $error("phase overlap");
endmodule
bind atpc_ctrl atpc_ctrl_chk u_chk (.sys_clk_i, .sys_rst_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .adc_tick_o, .adc_divisor_o, .adc_busy_o, .adc_settle_o, .adc_sample_o, .adc_done_o);

/* File: atpc_ctrl_test.sv */
// self-checking bench for the converter timing block
`timescale 1ns/10ps
`include "atpc_consts.vh"
module atpc_ctrl_test;
    logic sys_clk_i = 0;
    logic sys_rst_i = 1;
    logic [13:0] avs_address_i = 14'h0;
    logic avs_read_i = 0;
    logic avs_write_i = 0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0] avs_byteenable_i = 4'hF;
    wire [31:0] avs_readdata_o;
    wire avs_waitrequest_o, adc_tick_o, adc_busy_o, adc_settle_o, adc_sample_o, adc_done_o;
    wire [3:0] adc_divisor_o;
    int err_total = 0;
    int samples_checked = 0;
    logic [31:0] q, g, n_set, n_smp, n_done;
    localparam logic [13:0] A_SET = {`ATPC_IDX_SETTLE, 2'b00};
    localparam logic [13:0] A_SMP = {`ATPC_IDX_SAMPLE, 2'b00};
    localparam logic [13:0] A_DIV = {`ATPC_IDX_DIVIDER, 2'b00};
    localparam logic [13:0] A_RUN = {`ATPC_IDX_START, 2'b00};
    logic [31:0] dsel [6] = '{0, 1, 2, 4, 3, 7};
    logic [31:0] dexp [6] = '{1, 2, 4, 8, 4, 8};
    always #2.5 sys_clk_i = ~sys_clk_i;
    atpc_ctrl dut (.sys_clk_i, .sys_rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
        .adc_tick_o, .adc_divisor_o, .adc_busy_o, .adc_settle_o, .adc_sample_o, .adc_done_o);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one access, request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [13:0] a, input logic [31:0] d,
        input logic [3:0] be = 4'hF);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        avs_write_i <= w;
        avs_read_i <= !w;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        if (n >= 50) chk(32'h1, 32'h0);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task automatic rd(input logic [13:0] a, input logic [31:0] exp);
        bus(0, a, 32'h0);
        chk(q, exp);
    endtask
    // edges from one converter tick to the next; a lost tick ends the wait
    task automatic gap();
        g = 0;
        do @(posedge sys_clk_i); while (adc_tick_o !== 1'b1 && ++g < 20);
        g = 0;
        do @(posedge sys_clk_i); while (adc_tick_o !== 1'b1 && ++g < 20);
        g++;
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #20000;
        err_total++;
        close_out();
    end
    initial begin
        repeat (6) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        rd(A_SET, 32'h0F);
        rd(A_SMP, 32'h3F);
        rd(A_DIV, 32'h00);
        rd(14'h3DE0, 32'h0);
        $display("reset test done");
        bus(1, A_SET, 32'hA5);
        rd(A_SET, 32'h05);
        bus(1, A_SET, 32'h03, 4'h0);
        rd(A_SET, 32'h05);
        bus(1, A_SMP, 32'hFF);
        rd(A_SMP, 32'h3F);
        $display("field test done");
        for (int i = 0; i < 6; i++) begin
            bus(1, A_DIV, dsel[i]);
            rd(A_DIV, dsel[i]);
            gap();
            gap();
            chk(g, dexp[i]);
        end
        $display("divider test done");
        bus(1, A_SET, 32'h0F);
        bus(1, A_DIV, 32'h0);
        bus(1, A_RUN, 32'h0);
        rd(A_RUN, 32'h0);
        {n_set, n_smp, n_done} = '0;
        // second start lands in the settle phase and must not restart it
        fork
            begin
                bus(1, A_RUN, 32'h80);
                bus(1, A_RUN, 32'h80);
                rd(A_RUN, 32'h80);
            end
            repeat (150) begin
                @(posedge sys_clk_i);
                n_set += (adc_settle_o === 1'b1);
                n_smp += (adc_sample_o === 1'b1);
                n_done += (adc_done_o === 1'b1);
            end
        join
        chk(n_set, 32'd16);
        chk(n_smp, 32'd64);
        chk(n_done, 32'd1);
        rd(A_RUN, 32'h0);
        $display("conversion test done");
        close_out();
    end
endmodule

/* File: atpc_prescaler.v */
// converter clock prescaler: one-cycle tick at sys rate divided by 1, 2, 4 or 8
`timescale 1ns/10ps
`include "atpc_consts.vh"
module atpc_prescaler (
    // clock and reset
    input wire sys_clk_i,
    input wire sys_rst_i,
    // divide select bits
    input wire [`ATPC_DIV_W-1:0] div_sel_i,
    // converter clock enable tick and divisor in use
    output reg tick_o,
    output reg [3:0] divisor_o
);
    reg [2:0] cnt;
    reg [2:0] next_cnt;
    reg [2:0] limit;

    // largest selected divisor wins so the rate is always defined
    always @* begin
        if (div_sel_i[`ATPC_EIGHTH_BIT]) begin
            limit = 3'h7;
        end else if (div_sel_i[`ATPC_QUARTER_BIT]) begin
            limit = 3'h3;
        end else if (div_sel_i[`ATPC_HALF_BIT]) begin
            limit = 3'h1;
        end else begin
            limit = 3'h0;
        end
        next_cnt = (cnt >= limit) ? 3'h0 : cnt + 3'h1;
    end

    // counter restarts cleanly when the selection shrinks below the count
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            cnt <= 3'h0;
            tick_o <= 1'b0;
            divisor_o <= 4'h1;
        end else begin
            cnt <= next_cnt;
            tick_o <= (cnt >= limit);
            divisor_o <= {1'b0, limit} + 4'h1;
        end
    end
endmodule

/* File: atpc_sequencer.v */
// conversion sequencer: settle and sample/hold on system clocks, then convert on converter ticks
`timescale 1ns/10ps
`include "atpc_consts.vh"
module atpc_sequencer (
    // clock and reset
    input wire sys_clk_i,
    input wire sys_rst_i,
    // timing setup and start request
    input wire tick_i,
    input wire start_i,
    input wire [`ATPC_SETTLE_W-1:0] settle_count_i,
    input wire [`ATPC_SAMPLE_W-1:0] sample_hold_count_i,
    // phase outputs
    output reg busy_o,
    output reg settle_o,
    output reg sample_o,
    output reg done_o
);
    localparam PH_IDLE = 4'h1;
    localparam PH_SETTLE = 4'h2;
    localparam PH_SAMPLE = 4'h4;
    localparam PH_CONV = 4'h8;
    reg [3:0] state;
    reg [5:0] cnt;

    // phases count system clocks; conversion steps count converter ticks
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state <= PH_IDLE;
            cnt <= 6'h00;
            busy_o <= 1'b0;
            settle_o <= 1'b0;
            sample_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            case (state)
                PH_IDLE: begin
                    if (start_i) begin
                        state <= PH_SETTLE;
                        cnt <= {2'b00, settle_count_i};
                        busy_o <= 1'b1;
                        settle_o <= 1'b1;
                    end
                end
                PH_SETTLE: begin
                    if (cnt == 6'h00) begin
                        state <= PH_SAMPLE;
                        cnt <= sample_hold_count_i;
                        settle_o <= 1'b0;
                        sample_o <= 1'b1;
                    end else begin
                        cnt <= cnt - 6'h01;
                    end
                end
                PH_SAMPLE: begin
                    if (cnt == 6'h00) begin
                        state <= PH_CONV;
                        cnt <= 6'd`ATPC_CONV_TICKS;
                        sample_o <= 1'b0;
                    end else begin
                        cnt <= cnt - 6'h01;
                    end
                end
                PH_CONV: begin
                    if (tick_i) begin
                        if (cnt == 6'h01) begin
                            state <= PH_IDLE;
                            busy_o <= 1'b0;
                            done_o <= 1'b1;
                        end
                        cnt <= cnt - 6'h01;
                    end
                end
                default: begin
                    state <= PH_IDLE;
                    busy_o <= 1'b0;
                    settle_o <= 1'b0;
                    sample_o <= 1'b0;
                end
            endcase
        end
    end
endmodule
